/* core/flash_guard_pkg.sv */
// Shared constants and types for the flash command guard and block protection
package flash_guard_pkg;

  // ***************************************
  // Register byte offsets
  // ***************************************
  localparam logic [7:0] OFS_CLK_DIV = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_PROT = 8'h0c;
  localparam logic [7:0] OFS_ARRAY = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ***************************************
  // Status register bits
  // ***************************************
  localparam int STAT_CBEF = 7;
  localparam int STAT_CCIF = 6;
  localparam int STAT_PVIOL = 5;
  localparam int STAT_ACCERR = 4;

  // ***************************************
  // Interrupt bits
  // ***************************************
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ACCERR = 1;
  localparam int IRQ_PVIOL = 2;

  // ***************************************
  // Array write word layout
  // ***************************************
  localparam int ARR_ADDR_LSB = 0;
  localparam int ARR_DATA_LSB = 16;

  // ***************************************
  // Command codes
  // ***************************************
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
  localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
  localparam logic [7:0] CMD_BURST_PROG = 8'h25;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h41;

  // ***************************************
  // Protection
  // ***************************************
  localparam logic [7:0] PROT_RESET = 8'hff;
  localparam int PROT_DIS_BIT = 0;
  localparam logic [8:0] PROT_LOW_ONES = 9'h1ff;
  localparam logic [15:0] FLASH_LAST_ADDR = 16'hffff;

  typedef enum logic [1:0] {ST_IDLE, ST_GOT_ADDR, ST_GOT_CMD, ST_BUSY} guard_state_t;

endpackage

/* core/flash_command_guard_protect.sv */
// Flash command protocol checker with block protection and Avalon-MM registers
`timescale 1ns/1ps
module flash_command_guard_protect #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bdm_access,
  input wire logic chip_secured,
  input wire logic stop_mode,
  input wire logic [7:0] nv_prot_byte,
  input wire logic flash_op_done,
  output logic flash_op_start,
  output logic flash_op_abort,
  output logic [7:0] flash_op_cmd,
  output logic [15:0] flash_op_addr,
  output logic [7:0] flash_op_data,
  output logic [7:0] clk_div_out,
  output logic irq
);

  // ***************************************
  // Helper functions
  // ***************************************
  function automatic logic code_legal(input logic [7:0] c);
    code_legal = (c == flash_guard_pkg::CMD_BLANK_CHECK) ||
                 (c == flash_guard_pkg::CMD_BYTE_PROG) ||
                 (c == flash_guard_pkg::CMD_BURST_PROG) ||
                 (c == flash_guard_pkg::CMD_PAGE_ERASE) ||
                 (c == flash_guard_pkg::CMD_MASS_ERASE);
  endfunction

  function automatic logic code_alters(input logic [7:0] c);
    code_alters = (c == flash_guard_pkg::CMD_BYTE_PROG) ||
                  (c == flash_guard_pkg::CMD_BURST_PROG) ||
                  (c == flash_guard_pkg::CMD_PAGE_ERASE);
  endfunction

  // ***************************************
  // State
  // ***************************************
  flash_guard_pkg::guard_state_t state_r, state_nxt;
  logic ack_r;
  logic [31:0] rdata_r;
  logic div_set_r;
  logic [7:0] div_r;
  logic [7:0] prot_r;
  logic prot_load_r;
  logic accerr_r, accerr_nxt;
  logic pviol_r, pviol_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic start_r, start_nxt;
  logic abort_r, abort_nxt;
  logic [flash_guard_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [flash_guard_pkg::IRQ_W-1:0] irq_mask_r;
  logic acc_set, pv_set, done_set;

  // ***************************************
  // Bus decode
  // ***************************************
  wire logic bus_req = avs_read | avs_write;
  wire logic wr_go = avs_write & ack_r;
  wire logic rd_cap = avs_read & ~ack_r;
  wire logic [7:0] ofs = 8'(avs_address);
  wire logic [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [31:0] wd = avs_writedata & be_mask;
  wire logic sel_div = ofs == flash_guard_pkg::OFS_CLK_DIV;
  wire logic sel_stat = ofs == flash_guard_pkg::OFS_STATUS;
  wire logic sel_cmd = ofs == flash_guard_pkg::OFS_CMD;
  wire logic sel_prot = ofs == flash_guard_pkg::OFS_PROT;
  wire logic sel_arr = ofs == flash_guard_pkg::OFS_ARRAY;
  wire logic sel_ist = ofs == flash_guard_pkg::OFS_IRQ_STAT;
  wire logic sel_imask = ofs == flash_guard_pkg::OFS_IRQ_MASK;
  wire logic div_wr = wr_go & sel_div & avs_byteenable[0];
  wire logic stat_wr = wr_go & sel_stat & avs_byteenable[0];
  wire logic cmd_wr = wr_go & sel_cmd & avs_byteenable[0];
  wire logic prot_wr = wr_go & sel_prot & avs_byteenable[0];
  wire logic arr_wr = wr_go & sel_arr;
  // Command writes are refused while the error flag stands
  // refuse while flagged
  wire logic arr_ok = arr_wr & ~accerr_r;
  wire logic cmd_ok = cmd_wr & ~accerr_r;
  wire logic stat_ok = stat_wr & ~accerr_r;
  wire logic ctrl_wr = div_wr | prot_wr;
  wire logic [7:0] wcmd = wd[7:0];
  wire logic launch_bit = wd[flash_guard_pkg::STAT_CBEF];

  assign avs_waitrequest = bus_req & ~ack_r;

  // ***************************************
  // Protection region
  // ***************************************
  // disable at bit zero
  wire logic prot_en = ~prot_r[flash_guard_pkg::PROT_DIS_BIT];
  wire logic [15:0] last_unprot = {prot_r[7:1], flash_guard_pkg::PROT_LOW_ONES};
  // top block always inside a nonempty region
  wire logic region_nonempty = prot_en & (last_unprot != flash_guard_pkg::FLASH_LAST_ADDR);
  // region runs to the last address
  wire logic addr_hit = region_nonempty & (addr_r > last_unprot) &
                        (addr_r <= flash_guard_pkg::FLASH_LAST_ADDR);
  wire logic launch_blocked = (code_alters(cmd_r) & addr_hit) |
                              ((cmd_r == flash_guard_pkg::CMD_MASS_ERASE) & region_nonempty);

  // ***************************************
  // Command checks
  // ***************************************
  // legal codes only
  wire logic bad_code = ~code_legal(wcmd);
  wire logic secure_block = chip_secured & bdm_access & code_alters(wcmd);
  wire logic cmd_bad = bad_code | secure_block;
  wire logic arr_no_div = ~div_set_r;

  // ***************************************
  // Protocol sequencer
  // ***************************************
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    cmd_nxt = cmd_r;
    start_nxt = 1'b0;
    abort_nxt = 1'b0;
    acc_set = 1'b0;
    pv_set = 1'b0;
    done_set = 1'b0;
    unique case (state_r)
      flash_guard_pkg::ST_IDLE: begin
        if (arr_ok) begin
          if (arr_no_div) begin
            acc_set = 1'b1;
          end else begin
            state_nxt = flash_guard_pkg::ST_GOT_ADDR;
            addr_nxt = wd[flash_guard_pkg::ARR_ADDR_LSB +: 16];
            data_nxt = wd[flash_guard_pkg::ARR_DATA_LSB +: 8];
          end
        end else if (cmd_ok) begin
          acc_set = 1'b1;
        end
      end
      flash_guard_pkg::ST_GOT_ADDR: begin
        if (cmd_ok) begin
          if (cmd_bad) begin
            acc_set = 1'b1;
          end else begin
            state_nxt = flash_guard_pkg::ST_GOT_CMD;
            cmd_nxt = wcmd;
          end
        end else if (arr_ok) begin
          acc_set = 1'b1;
        end else if (ctrl_wr) begin
          acc_set = 1'b1;
        end else if (stat_ok) begin
          acc_set = 1'b1;
          if (!launch_bit) begin
            state_nxt = flash_guard_pkg::ST_IDLE;
          end
        end
      end
      flash_guard_pkg::ST_GOT_CMD: begin
        if (arr_ok || ctrl_wr) begin
          acc_set = 1'b1;
        end else if (cmd_ok) begin
          acc_set = 1'b1;
        end else if (stat_ok) begin
          if (!launch_bit) begin
            acc_set = 1'b1;
            state_nxt = flash_guard_pkg::ST_IDLE;
          end else if (launch_blocked) begin
            pv_set = 1'b1;
            state_nxt = flash_guard_pkg::ST_IDLE;
          end else begin
            start_nxt = 1'b1;
            state_nxt = flash_guard_pkg::ST_BUSY;
          end
        end
      end
      flash_guard_pkg::ST_BUSY: begin
        if (stop_mode && code_alters(cmd_r)) begin
          abort_nxt = 1'b1;
          acc_set = 1'b1;
          state_nxt = flash_guard_pkg::ST_IDLE;
        end else if (flash_op_done) begin
          done_set = 1'b1;
          state_nxt = flash_guard_pkg::ST_IDLE;
        end
        if (arr_ok || cmd_ok) begin
          acc_set = 1'b1;
        end
      end
    endcase
  end

  // ***************************************
  // Flags: set wins over clear
  // ***************************************
  wire logic acc_clr = stat_wr & wd[flash_guard_pkg::STAT_ACCERR];
  wire logic pv_clr = stat_wr & wd[flash_guard_pkg::STAT_PVIOL];
  assign accerr_nxt = acc_set | (accerr_r & ~acc_clr);
  assign pviol_nxt = pv_set | (pviol_r & ~pv_clr);
  wire logic [flash_guard_pkg::IRQ_W-1:0] irq_ev = {pv_set, acc_set, done_set};
  wire logic [flash_guard_pkg::IRQ_W-1:0] irq_clr =
    (wr_go & sel_ist) ? wd[flash_guard_pkg::IRQ_W-1:0] : '0;
  assign irq_stat_nxt = irq_ev | (irq_stat_r & ~irq_clr);
  assign irq = |(irq_stat_r & irq_mask_r);

  // ***************************************
  // Read mux
  // ***************************************
  wire logic [7:0] stat_val = {state_r != flash_guard_pkg::ST_BUSY,
                               state_r == flash_guard_pkg::ST_IDLE,
                               pviol_r, accerr_r, 4'h0};
  wire logic [31:0] rd_mux =
    sel_div ? {24'h0, div_r} :
    sel_stat ? {24'h0, stat_val} :
    sel_cmd ? {24'h0, cmd_r} :
    sel_prot ? {24'h0, prot_r} :
    sel_arr ? {8'h0, data_r, addr_r} :
    sel_ist ? {29'h0, irq_stat_r} :
    sel_imask ? {29'h0, irq_mask_r} : 32'h0;

  // ***************************************
  // Bus handshake registers
  // ***************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (rd_cap) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ***************************************
  // Sequencer registers
  // ***************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= flash_guard_pkg::ST_IDLE;
      addr_r <= 16'h0;
      data_r <= 8'h0;
      cmd_r <= 8'h0;
      start_r <= 1'b0;
      abort_r <= 1'b0;
      accerr_r <= 1'b0;
      pviol_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      cmd_r <= cmd_nxt;
      start_r <= start_nxt;
      abort_r <= abort_nxt;
      accerr_r <= accerr_nxt;
      pviol_r <= pviol_nxt;
    end
  end

  // ***************************************
  // Divider and interrupt registers
  // ***************************************
  wire logic pending = (state_r == flash_guard_pkg::ST_GOT_ADDR) |
                       (state_r == flash_guard_pkg::ST_GOT_CMD);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_r <= 8'h0;
      div_set_r <= 1'b0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      if (div_wr && !pending) begin
        div_r <= wd[7:0];
        div_set_r <= 1'b1;
      end
      irq_stat_r <= irq_stat_nxt;
      if (wr_go && sel_imask) begin
        irq_mask_r <= wd[flash_guard_pkg::IRQ_W-1:0];
      end
    end
  end

  // ***************************************
  // Protection register
  // ***************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prot_r <= flash_guard_pkg::PROT_RESET;
      prot_load_r <= 1'b1;
    end else if (prot_load_r) begin
      prot_r <= nv_prot_byte;
      prot_load_r <= 1'b0;
    end else if (prot_wr && bdm_access && !pending) begin
      prot_r <= wd[7:0];
    end
  end

  // ***************************************
  // Outputs
  // ***************************************
  assign avs_readdata = rdata_r;
  assign flash_op_start = start_r;
  assign flash_op_abort = abort_r;
  assign flash_op_cmd = cmd_r;
  assign flash_op_addr = addr_r;
  assign flash_op_data = data_r;
  assign clk_div_out = div_r;

endmodule

/* tb/flash_guard_assertions.sv */
// Concurrent checks on the flash command guard ports
`timescale 1ns/1ps
module flash_guard_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic bdm_access,
  input wire logic chip_secured,
  input wire logic stop_mode,
  input wire logic flash_op_done,
  input wire logic flash_op_start,
  input wire logic flash_op_abort,
  input wire logic [7:0] flash_op_cmd,
  input wire logic [15:0] flash_op_addr
);
  logic busy_r;
  logic busy_nxt;
  wire logic launch_w = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_writedata[7]
    && avs_address == ADDR_W'(flash_guard_pkg::OFS_STATUS);
  wire logic prog_w = flash_op_cmd == flash_guard_pkg::CMD_BYTE_PROG
    || flash_op_cmd == flash_guard_pkg::CMD_BURST_PROG
    || flash_op_cmd == flash_guard_pkg::CMD_PAGE_ERASE;
  wire logic legal_w = prog_w || flash_op_cmd == flash_guard_pkg::CMD_BLANK_CHECK
    || flash_op_cmd == flash_guard_pkg::CMD_MASS_ERASE;
  wire logic busy_w = flash_op_start || busy_r;
  assign busy_nxt = busy_w && !flash_op_done && !(stop_mode && prog_w);
  // Tracks a running command from launch to done or abort
  always_ff @(posedge clk_sys) begin
    busy_r <= sys_rst ? 1'h0 : busy_nxt;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence seq_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence seq_hold;
    ($stable(flash_op_cmd) && $stable(flash_op_addr)) [*3];
  endsequence
  chk_wait_one: assert property (($rose(avs_write) || $rose(avs_read)) |-> seq_answer)
    else $error("waitrequest did not drop one cycle after the request");
  chk_start_cause: assert property (flash_op_start |-> $past(launch_w))
    else $error("start without a launching status write");
  chk_start_legal: assert property (flash_op_start |-> legal_w)
    else $error("start with an illegal command code");
  chk_no_restart: assert property (flash_op_start |-> !busy_r)
    else $error("start while a command is still running");
  chk_stop_abort: assert property (busy_w && stop_mode && prog_w |=> flash_op_abort)
    else $error("stop during program or erase gave no abort");
  chk_abort_cause: assert property (flash_op_abort |-> $past(busy_w && stop_mode && prog_w))
    else $error("abort without stop during program or erase");
  chk_cmd_hold: assert property (flash_op_start |=> seq_hold)
    else $error("running command or address changed");
  chk_secure_only: assert property (flash_op_start && $past(chip_secured && bdm_access) |-> !prog_w)
    else $error("secured debug started a program or page erase");
endmodule
bind flash_command_guard_protect flash_guard_assertions #(.ADDR_W(ADDR_W)) flash_guard_assertions_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .bdm_access(bdm_access), .chip_secured(chip_secured),
  .stop_mode(stop_mode), .flash_op_done(flash_op_done), .flash_op_start(flash_op_start),
  .flash_op_abort(flash_op_abort), .flash_op_cmd(flash_op_cmd), .flash_op_addr(flash_op_addr)
);

/* tb/testbench.sv */
// Self-checking bench for the flash command guard
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] DV = flash_guard_pkg::OFS_CLK_DIV;
  localparam logic [7:0] ST = flash_guard_pkg::OFS_STATUS;
  localparam logic [7:0] CM = flash_guard_pkg::OFS_CMD;
  localparam logic [7:0] PR = flash_guard_pkg::OFS_PROT;
  localparam logic [7:0] AR = flash_guard_pkg::OFS_ARRAY;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic bdm_access = 1'h0;
  logic chip_secured = 1'h0;
  logic stop_mode = 1'h0;
  logic [7:0] nv_prot_byte = 8'hf8;
  logic flash_op_done = 1'h0;
  logic flash_op_start;
  logic flash_op_abort;
  logic [7:0] flash_op_cmd;
  logic [15:0] flash_op_addr;
  logic [7:0] flash_op_data;
  logic [7:0] clk_div_out;
  logic irq;
  int mismatches = 0;
  int total_checks = 0;
  logic [31:0] rd_q[$];
  logic [32:0] op_q[$];
  logic [15:0] a;
  logic [7:0] d;
  logic [7:0] codes[5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  logic [15:0] bounds[3] = '{16'hf9ff, 16'hfa00, 16'hffff};
  always #10 clk_sys = ~clk_sys;
  flash_command_guard_protect flash_command_guard_protect_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bdm_access(bdm_access),
    .chip_secured(chip_secured), .stop_mode(stop_mode), .nv_prot_byte(nv_prot_byte),
    .flash_op_done(flash_op_done), .flash_op_start(flash_op_start),
    .flash_op_abort(flash_op_abort), .flash_op_cmd(flash_op_cmd), .flash_op_addr(flash_op_addr),
    .flash_op_data(flash_op_data), .clk_div_out(clk_div_out), .irq(irq)
  );
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic rd, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_read <= rd;
    avs_write <= !rd;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    if (avs_waitrequest !== 1'h0) begin
      mismatches++;
      final_report();
    end
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(1'h0, ad, wd);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'h1, ad, 32'h0);
  endtask
  task automatic settle();
    int n;
    n = 0;
    while (op_q.size() != 0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (op_q.size() != 0) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic run_cmd(input logic [15:0] ad, input logic [7:0] dt, input logic [7:0] c,
    input logic go);
    wr(AR, {8'h00, dt, ad});
    wr(CM, {24'h0, c});
    if (go) begin
      op_q.push_back({1'h0, c, ad, dt});
    end
    wr(ST, 32'h80);
    settle();
  endtask
  task automatic op_done();
    @(posedge clk_sys);
    flash_op_done <= 1'h1;
    @(posedge clk_sys);
    flash_op_done <= 1'h0;
  endtask
  // Compares each read answer and each launch or abort with the oldest note
  always @(posedge clk_sys) begin
    if (avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
      chk("readdata", {1'h0, rd_q.size() != 0 ? rd_q.pop_front() : 32'hx}, {1'h0, avs_readdata});
    end
    if (flash_op_start === 1'h1 || flash_op_abort === 1'h1) begin
      chk("flash_op", op_q.size() != 0 ? op_q.pop_front() : 33'hx,
        {flash_op_abort, flash_op_cmd, flash_op_addr, flash_op_data});
    end
  end
  initial begin
    void'($urandom(32'h1c9f8356));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(PR, 32'hf8);
    rd(ST, 32'hc0);
    wr(flash_guard_pkg::OFS_IRQ_MASK, 32'h2);
    wr(AR, 32'h0);
    rd(ST, 32'hd0);
    @(negedge clk_sys);
    chk("irq", 33'h1, {32'h0, irq});
    wr(DV, 32'h13);
    run_cmd(16'h0100, 8'h5a, codes[1], 1'h0);
    chk("clk_div", 33'h13, {25'h0, clk_div_out});
    rd(ST, 32'hd0);
    wr(ST, 32'h10);
    rd(ST, 32'hc0);
    wr(flash_guard_pkg::OFS_IRQ_STAT, 32'h2);
    @(negedge clk_sys);
    chk("irq", 33'h0, {32'h0, irq});
    for (int i = 0; i < 5; i++) begin
      a = 16'($urandom_range(32'hf9ff));
      d = 8'($urandom);
      run_cmd(a, d, codes[i], codes[i] != 8'h41);
      if (i == 0) begin
        wr(AR, 32'h0);
        rd(ST, 32'h10);
      end
      op_done();
      rd(ST, (codes[i] == 8'h41) ? 32'he0 : ((i == 0) ? 32'hd0 : 32'hc0));
      wr(ST, 32'h30);
    end
    for (int j = 0; j < 3; j++) begin
      run_cmd(bounds[j], 8'h11, codes[3], j == 0);
      op_done();
      rd(ST, (j == 0) ? 32'hc0 : 32'he0);
      wr(ST, 32'h20);
    end
    for (int k = 0; k < 6; k++) begin
      wr(AR, 32'h00220200);
      case (k)
        0: wr(AR, 32'h00220200);
        1: begin wr(CM, 32'h20); wr(CM, 32'h20); end
        2: wr(DV, 32'h27);
        3: wr(CM, 32'h21);
        4: begin wr(CM, 32'h20); wr(DV, 32'h27); end
        default: wr(ST, 32'h0);
      endcase
      rd(ST, (k == 5) ? 32'hd0 : 32'h90);
      wr(ST, 32'h10);
      wr(ST, 32'h0);
      wr(ST, 32'h10);
      rd(ST, 32'hc0);
    end
    chk("clk_div", 33'h13, {25'h0, clk_div_out});
    chip_secured <= 1'h1;
    bdm_access <= 1'h1;
    run_cmd(16'h0300, 8'h33, codes[1], 1'h0);
    rd(ST, 32'h90);
    wr(ST, 32'h10);
    wr(ST, 32'h0);
    wr(ST, 32'h10);
    run_cmd(16'h0300, 8'h33, codes[0], 1'h1);
    op_done();
    chip_secured <= 1'h0;
    bdm_access <= 1'h0;
    wr(PR, 32'hff);
    rd(PR, 32'hf8);
    bdm_access <= 1'h1;
    wr(PR, 32'hff);
    rd(PR, 32'hff);
    bdm_access <= 1'h0;
    run_cmd(16'hffff, 8'h44, codes[4], 1'h1);
    op_done();
    run_cmd(16'h1000, 8'h55, codes[3], 1'h1);
    op_q.push_back({1'h1, codes[3], 16'h1000, 8'h55});
    stop_mode <= 1'h1;
    settle();
    stop_mode <= 1'h0;
    rd(ST, 32'hd0);
    wr(ST, 32'h10);
    wr(8'h40, 32'hff);
    rd(8'h40, 32'h0);
    nv_prot_byte <= 8'h01;
    sys_rst <= 1'h1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(PR, 32'h01);
    final_report();
  end
endmodule
